// ---- sfw_defs.svh ----
// register offsets, field positions, reset values and sizes of the shared fifo
// assumes inclusion by the fifo package and module only
`ifndef SFW_DEFS_SVH
`define SFW_DEFS_SVH

`define SFW_ADDR_CONTROL 8'h02
`define SFW_ADDR_WATERMARK 8'h03
`define SFW_ADDR_LENGTH 8'h04
`define SFW_ADDR_DATA 8'h05
`define SFW_ADDR_IRQ_STATUS_REG0 8'h06
`define SFW_ADDR_IRQ_STATUS_REG0_EN 8'h08

// control register fields
`define SFW_CTL_SIZE_BIT 7
`define SFW_CTL_FLUSH_BIT 4
`define SFW_CTL_WM_HI_BIT 2
`define SFW_CTL_FULL_ALERT_BIT 6
`define SFW_CTL_EMPTY_ALERT_BIT 5
`define SFW_CTL_FILL_HI_BIT 0

// irq registers
`define SFW_IRQ_SET_BIT 7
`define SFW_IRQ_FULL_ALERT_BIT 3
`define SFW_IRQ_EMPTY_ALERT_BIT 2
`define SFW_IRQ_ERR_BIT 1

`define SFW_DEPTH_LARGE 512
`define SFW_DEPTH_SMALL 255
`define SFW_WM_RESET 9'h008
`endif

// ---- sfw_engine_model.sv ----
// command engine model: runs one command that pushes two bytes, then pops one
// assumes the fifo clock and reset
`timescale 1ns/100ps
module sfw_engine_model (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // control and fifo side
    input wire logic start_i,
    output logic cmd_active_o,
    output sfw_pkg::sfw_core_req_t core_req_o
);
    import sfw_pkg::*;
    logic [2:0] cnt_reg;
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            cnt_reg <= 3'h0;
            cmd_active_o <= 1'b0;
            core_req_o <= '0;
        end
        else if (cmd_active_o)
        begin
            // pushes only once the fifo has handed the buffer over
            cnt_reg <= cnt_reg + 3'h1;
            core_req_o <= '{cnt_reg == 3'h1 || cnt_reg == 3'h2, cnt_reg == 3'h3, 8'h5a ^ {5'h00, cnt_reg}};
            cmd_active_o <= cnt_reg != 3'h4;
        end
        else
        begin
            cnt_reg <= 3'h0;
            cmd_active_o <= start_i;
        end
    end
endmodule

// ---- sfw_fifo.sv ----
// shared 512x8 fifo with flush, fill count, watermark alerts, overflow and irq pin
// assumes a host register port and a command engine port on the same clock
//
// Operation
// - a byte-wide 512-entry buffer carries data both ways between host and command engine.
// - with the size-select bit at 1 the buffer holds at most 255 bytes.
// - in 255-byte mode the level fits one byte, in 512-byte mode it takes two; the watermark takes two in both.
// - during a command the engine may push and pop the buffer itself.
// - writing 1 to the flush bit resets the pointers and zeroes the fill level.
// - outside a command, each host data write into a non-full buffer raises the fill level by one and each host data read from a non-empty one lowers it by one.
// - the fill level is read from the length register, its bit 8 also in control in 512-byte mode.
// - the watermark is nine bits, low eight at 03h and the top bit at 02h bit 2.
// - one watermark sets both the almost-full and almost-empty thresholds.
// - almost-full is 1 when size minus fill level is at most the watermark.
// - almost-empty is 1 when the fill level is at most the watermark.
// - outside a command, a host write into a full buffer sets the overflow flag shown as the error irq bit.
// - with its enable set, a rise of almost-empty asserts the irq pin.
// - with its enable set, a rise of almost-full asserts the irq pin.
`timescale 1ns/100ps
`include "sfw_defs.svh"

module sfw_fifo #(
    parameter int DEPTH = `SFW_DEPTH_LARGE,
    parameter int SMALL_DEPTH = `SFW_DEPTH_SMALL
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // host register port
    input wire sfw_pkg::sfw_reg_req_t host_req_i,
    output logic [7:0] host_rdata_o,
    // command engine port
    input wire logic cmd_active_i,
    input wire sfw_pkg::sfw_core_req_t core_req_i,
    output logic [7:0] core_rdata_o,
    output logic core_empty_o,
    output logic core_full_o,
    // status
    output logic almost_full_flag_o,
    output logic almost_empty_flag_o,
    output logic irq_o
);
    import sfw_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [7:0] mem [0:DEPTH-1];
    logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [AW:0] fill_reg, fill_next;
    logic [8:0] wm_reg, wm_next;
    logic size_small_reg, size_small_next;
    logic full_alert_reg, full_alert_next;
    logic empty_alert_reg, empty_alert_next;
    logic ovf_reg, ovf_next;
    logic [7:0] irq_en_reg, irq_en_next;
    logic [7:0] host_rdata_reg, host_rdata_next;
    logic [7:0] core_rdata_reg, core_rdata_next;
    logic irq_reg, irq_next;
    sfw_state_t state_reg, state_next;

    logic [AW:0] cap;
    logic full, empty, push, pop, flush, host_wr_data, host_rd_data;
    logic [7:0] wdata;
    logic [9:0] space;
    logic fa_now, ea_now;

    always_comb
    begin
        cap = size_small_reg ? (AW+1)'(SMALL_DEPTH) : (AW+1)'(DEPTH);
        full = fill_reg >= cap;
        empty = fill_reg == '0;
        host_wr_data = host_req_i.wr && host_req_i.addr == `SFW_ADDR_DATA;
        host_rd_data = host_req_i.rd && host_req_i.addr == `SFW_ADDR_DATA;
        flush = host_req_i.wr && host_req_i.addr == `SFW_ADDR_CONTROL
            && host_req_i.wdata[`SFW_CTL_FLUSH_BIT];
        // engine owns the buffer during a command; host side collisions are its own care
        if (state_reg == SFW_BUSY)
        begin
            push = core_req_i.push && !full;
            pop = core_req_i.pop && !empty;
            wdata = core_req_i.wdata;
        end
        else
        begin
            push = host_wr_data && !full;
            pop = host_rd_data && !empty;
            wdata = host_req_i.wdata;
        end
        space = 10'(cap) - 10'(fill_reg);
        // a level beyond the selected size counts as full, so a size cut never hides the alert
        fa_now = full || space <= 10'(wm_reg);
        ea_now = 10'(fill_reg) <= 10'(wm_reg);
    end

    // pointer and fill group
    always_comb
    begin
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        fill_next = fill_reg + (AW+1)'(push) - (AW+1)'(pop);
        // pointers wrap at the selected size; one left beyond it by a size change wraps too
        if (push)
        begin
            wptr_next = (wptr_reg >= AW'(cap - 1'b1)) ? '0 : wptr_reg + 1'b1;
        end
        if (pop)
        begin
            rptr_next = (rptr_reg >= AW'(cap - 1'b1)) ? '0 : rptr_reg + 1'b1;
        end
        // flush outranks a data access in the same cycle
        if (flush)
        begin
            wptr_next = '0;
            rptr_next = '0;
            fill_next = '0;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            fill_reg <= '0;
        end
        else
        begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            fill_reg <= fill_next;
        end
    end

    // configuration group: size select, watermark and irq enables
    always_comb
    begin
        wm_next = wm_reg;
        size_small_next = size_small_reg;
        irq_en_next = irq_en_reg;
        if (host_req_i.wr)
        begin
            case (host_req_i.addr)
                `SFW_ADDR_CONTROL:
                begin
                    // a size change does not flush; software flushes around it
                    size_small_next = host_req_i.wdata[`SFW_CTL_SIZE_BIT];
                    wm_next[8] = host_req_i.wdata[`SFW_CTL_WM_HI_BIT];
                end
                `SFW_ADDR_WATERMARK: wm_next[7:0] = host_req_i.wdata;
                `SFW_ADDR_IRQ_STATUS_REG0_EN: irq_en_next = host_req_i.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            wm_reg <= `SFW_WM_RESET;
            size_small_reg <= 1'b0;
            irq_en_reg <= 8'h00;
        end
        else
        begin
            wm_reg <= wm_next;
            size_small_reg <= size_small_next;
            irq_en_reg <= irq_en_next;
        end
    end

    // status group: alert flags, overflow flag and the sticky irq pin
    always_comb
    begin
        full_alert_next = fa_now;
        empty_alert_next = ea_now;
        ovf_next = ovf_reg;
        irq_next = irq_reg;
        if (host_req_i.wr && host_req_i.addr == `SFW_ADDR_IRQ_STATUS_REG0)
        begin
            // set bit at 0 clears the overflow flag if marked, at 1 sets it; the pin drops unless an enabled rise sets it in the same cycle
            if (host_req_i.wdata[`SFW_IRQ_SET_BIT])
            begin
                ovf_next = ovf_reg | host_req_i.wdata[`SFW_IRQ_ERR_BIT];
            end
            else if (host_req_i.wdata[`SFW_IRQ_ERR_BIT])
            begin
                ovf_next = 1'b0;
            end
            irq_next = 1'b0;
        end
        // a write into a full buffer outranks a clear in the same cycle
        if (host_wr_data && full && state_reg == SFW_IDLE)
        begin
            ovf_next = 1'b1;
        end
        if ((irq_en_reg[`SFW_IRQ_EMPTY_ALERT_BIT] && ea_now && !empty_alert_reg)
            || (irq_en_reg[`SFW_IRQ_FULL_ALERT_BIT] && fa_now && !full_alert_reg)
            || (irq_en_reg[`SFW_IRQ_ERR_BIT] && ovf_next && !ovf_reg))
        begin
            irq_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            full_alert_reg <= 1'b0;
            // matches the idle almost-empty level so no false rise follows reset
            empty_alert_reg <= 1'b1;
            ovf_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            full_alert_reg <= full_alert_next;
            empty_alert_reg <= empty_alert_next;
            ovf_reg <= ovf_next;
            irq_reg <= irq_next;
        end
    end

    // read data group: host register reads and engine pops
    always_comb
    begin
        host_rdata_next = host_rdata_reg;
        core_rdata_next = core_rdata_reg;
        if (pop && state_reg == SFW_BUSY)
        begin
            core_rdata_next = mem[rptr_reg];
        end
        if (host_req_i.rd)
        begin
            case (host_req_i.addr)
                // control packs size, alerts, watermark bit 8 and fill bit 8
                `SFW_ADDR_CONTROL:
                    host_rdata_next = {size_small_reg, full_alert_reg, empty_alert_reg, 1'b0, 1'b0,
                        wm_reg[8], 1'b0, size_small_reg ? 1'b0 : fill_reg[8]};
                `SFW_ADDR_WATERMARK: host_rdata_next = wm_reg[7:0];
                `SFW_ADDR_LENGTH: host_rdata_next = fill_reg[7:0];
                // a host data read during a command gets zero, never the engine's byte
                `SFW_ADDR_DATA: host_rdata_next = (pop && state_reg == SFW_IDLE) ? mem[rptr_reg] : 8'h00;
                `SFW_ADDR_IRQ_STATUS_REG0:
                    host_rdata_next = {irq_reg, 3'h0, full_alert_reg, empty_alert_reg, ovf_reg, 1'b0};
                `SFW_ADDR_IRQ_STATUS_REG0_EN: host_rdata_next = irq_en_reg;
                default: host_rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            host_rdata_reg <= 8'h00;
            core_rdata_reg <= 8'h00;
        end
        else
        begin
            host_rdata_reg <= host_rdata_next;
            core_rdata_reg <= core_rdata_next;
        end
    end

    // buffer array, no reset needed
    always_ff @(posedge sys_clk_i)
    begin
        if (push)
            mem[wptr_reg] <= wdata;
    end

    // ownership group: the engine owns the buffer from the cycle after cmd_active_i rises
    always_comb
    begin
        case (state_reg)
            SFW_IDLE:
            begin
                state_next = cmd_active_i ? SFW_BUSY : SFW_IDLE;
            end
            SFW_BUSY:
            begin
                // the buffer returns to the host one cycle after the command ends
                state_next = cmd_active_i ? SFW_BUSY : SFW_IDLE;
            end
            default: state_next = SFW_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            state_reg <= SFW_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign host_rdata_o = host_rdata_reg;
    assign core_rdata_o = core_rdata_reg;
    assign core_empty_o = empty;
    assign core_full_o = full;
    assign almost_full_flag_o = full_alert_reg;
    assign almost_empty_flag_o = empty_alert_reg;
    assign irq_o = irq_reg;
endmodule

// ---- sfw_fifo_asserts.sv ----
// port assertions for the shared fifo
// assumes it is bound into sfw_fifo
`timescale 1ns/100ps
module sfw_fifo_asserts (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // host and engine
    input wire sfw_pkg::sfw_reg_req_t host_req_i,
    input wire logic [7:0] host_rdata_o,
    input wire logic cmd_active_i,
    input wire sfw_pkg::sfw_core_req_t core_req_i,
    input wire logic [7:0] core_rdata_o,
    input wire logic core_empty_o,
    input wire logic core_full_o,
    // status
    input wire logic almost_full_flag_o,
    input wire logic almost_empty_flag_o,
    input wire logic irq_o
);
    import sfw_pkg::*;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    a_reset_empty: assert property ($fell(reset_i) |-> almost_empty_flag_o && core_empty_o)
        else $error("not empty after reset");
    a_flush_empties: assert property (host_req_i.wr && host_req_i.addr == 8'h02 && host_req_i.wdata[4]
        |=> core_empty_o) else $error("flush left data");
    a_empty_lag: assert property (core_empty_o |=> almost_empty_flag_o)
        else $error("almost empty missing");
    a_full_lag: assert property (core_full_o |=> almost_full_flag_o)
        else $error("almost full missing");
    a_write_fills: assert property (host_req_i.wr && host_req_i.addr == 8'h05 && !$past(cmd_active_i)
        |=> !core_empty_o) else $error("write not stored");
    a_read_zero: assert property (host_req_i.rd && host_req_i.addr == 8'h05 && core_empty_o
        && !$past(cmd_active_i) |=> host_rdata_o == 8'h00) else $error("empty read not zero");
    a_push_fills: assert property ($past(cmd_active_i) && core_req_i.push && !core_req_i.pop
        |=> !core_empty_o) else $error("push not stored");
    a_irq_sticky: assert property (irq_o && !(host_req_i.wr && host_req_i.addr == 8'h06)
        |=> irq_o) else $error("irq dropped");
    a_not_both: assert property (!(core_empty_o && core_full_o))
        else $error("empty and full");
endmodule

bind sfw_fifo sfw_fifo_asserts sfw_fifo_asserts_inst (.sys_clk_i, .reset_i, .host_req_i, .host_rdata_o,
    .cmd_active_i, .core_req_i, .core_rdata_o, .core_empty_o, .core_full_o, .almost_full_flag_o,
    .almost_empty_flag_o, .irq_o);

// ---- sfw_fifo_tb_top.sv ----
// self-checking bench for the shared fifo
// assumes sfw_fifo, its checker and the engine model
`timescale 1ns/100ps
module sfw_fifo_tb_top;
    import sfw_pkg::*;
    logic clk = 0, rst = 1, start = 0, cmd_active, irq, p = 0;
    logic [7:0] rdata, core_rdata, d[10];
    logic [15:0] q[$];
    sfw_reg_req_t req = '0;
    sfw_core_req_t core_req;
    int failures = 0, cmp_count = 0, i, k;
    always #50 clk = ~clk;
    sfw_fifo sfw_fifo_inst (.sys_clk_i(clk), .reset_i(rst), .host_req_i(req), .host_rdata_o(rdata),
        .cmd_active_i(cmd_active), .core_req_i(core_req), .core_rdata_o(core_rdata), .core_empty_o(),
        .core_full_o(),
        .almost_full_flag_o(), .almost_empty_flag_o(), .irq_o(irq));
    sfw_engine_model sfw_engine_model_inst (.sys_clk_i(clk), .reset_i(rst), .start_i(start),
        .cmd_active_o(cmd_active), .core_req_o(core_req));
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        cmp_count++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    // one register access; a read notes its expected value and mask
    task automatic acc(logic w, logic [7:0] a, logic [7:0] v, logic [7:0] m = 8'hff);
        if (!w)
            q.push_back({m, v});
        @(posedge clk);
        req <= '{w, !w, a, v};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        if (p)
        begin
            chk("rdata", rdata & q[0][15:8], q[0][7:0]);
            q.delete(0);
        end
        p <= req.rd;
    end
    initial
    begin
        void'($urandom(45));
        repeat (4) @(posedge clk);
        rst <= 0;
        acc(0, 8'h03, 8'h08);
        acc(0, 8'h02, 8'h20);
        for (i = 0; i < 10; i++)
        begin
            d[i] = 8'($urandom);
            acc(1, 8'h05, d[i]);
        end
        acc(0, 8'h04, 8'h0a);
        for (i = 0; i < 10; i++)
            acc(0, 8'h05, d[i]);
        acc(0, 8'h05, 8'h00);
        acc(0, 8'h04, 8'h00);
        acc(1, 8'h03, 8'h03);
        repeat (4) acc(1, 8'h05, 8'($urandom));
        acc(0, 8'h02, 8'h00);
        acc(1, 8'h02, 8'h10);
        acc(0, 8'h04, 8'h00);
        acc(0, 8'h02, 8'h20);
        acc(1, 8'h08, 8'h08);
        acc(1, 8'h02, 8'h90);
        for (i = 0; i < 255; i++)
            acc(1, 8'h05, i[7:0]);
        acc(0, 8'h02, 8'hc0);
        #1 chk("irq", {7'h00, irq}, 8'h01);
        acc(1, 8'h05, 8'haa);
        acc(0, 8'h04, 8'hff);
        acc(0, 8'h06, 8'h02, 8'h02);
        acc(0, 8'h05, 8'h00);
        acc(1, 8'h06, 8'h02);
        #1 chk("irq", {7'h00, irq}, 8'h00);
        acc(1, 8'h08, 8'h04);
        acc(1, 8'h02, 8'h10);
        repeat (3) @(posedge clk);
        #1 chk("irq", {7'h00, irq}, 8'h01);
        acc(1, 8'h06, 8'h02);
        for (i = 0; i < 300; i++)
            acc(1, 8'h05, 8'($urandom));
        acc(0, 8'h04, 8'h2c);
        acc(0, 8'h02, 8'h01);
        acc(1, 8'h02, 8'h04);
        acc(0, 8'h02, 8'h45);
        acc(1, 8'h02, 8'h10);
        // oldest byte, taken by the engine's pop
        acc(1, 8'h05, 8'hc3);
        start <= 1;
        @(posedge clk);
        start <= 0;
        // host keeps off the buffer while the command runs
        for (k = 0; k < 20 && (cmd_active || k < 2); k++)
            @(posedge clk);
        if (cmd_active)
            failures++;
        else
        begin
            chk("core_rdata", core_rdata, 8'hc3);
            acc(0, 8'h04, 8'h02);
            acc(0, 8'h05, 8'h5b);
            acc(0, 8'h05, 8'h58);
            repeat (2) @(posedge clk);
        end
        wrap_up;
    end
endmodule

// ---- sfw_pkg.sv ----
// types for the shared fifo with watermarks
// assumes sfw_defs.svh for constants
package sfw_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfw_reg_req_t;

    typedef struct packed {
        logic       push;
        logic       pop;
        logic [7:0] wdata;
    } sfw_core_req_t;

    typedef enum logic {SFW_IDLE, SFW_BUSY} sfw_state_t;
endpackage
